// ===== freq_steer_pkg.sv
// shared constants and types for the frequency steering register bank
package freq_steer_pkg;

  // ==========================================================
  // register map (word addresses on the serial register port)
  localparam logic [7:0]  ADDR_WORD_LOW    = 8'h00;
  localparam logic [7:0]  ADDR_WORD_HIGH   = 8'h01;
  localparam logic [7:0]  ADDR_PULL_SPAN   = 8'h02;
  localparam int          HIGH_FIELD_MSB   = 9;
  localparam int          SOE_BIT_POS      = 10;
  localparam int          SPAN_FIELD_MSB   = 3;
  localparam logic [15:0] WORD_LOW_RESET   = 16'h0000;
  localparam logic [9:0]  WORD_HIGH_RESET  = 10'h000;
  localparam logic [3:0]  PULL_SPAN_RESET  = 4'h0;
  localparam logic        SOE_RESET        = 1'b0;

  // ==========================================================
  // control word format: 26-bit two's complement, full scale 2^25-1
  localparam int          WORD_W           = 26;
  localparam logic [25:0] WORD_POS_FULL    = 26'h1ff_ffff;

  // ==========================================================
  // timing at 250 MHz core clock
  localparam int          CLK_PERIOD_PS    = 4000;
  localparam int          PULL_DELAY_TYP_NS   = 103000;
  localparam int          PULL_DELAY_MAX_NS   = 140000;
  localparam int          SETTLE_MAX_NS       = 20000;
  localparam int          PULL_DELAY_CYC   = (PULL_DELAY_TYP_NS * 1000) / CLK_PERIOD_PS;
  localparam int          SETTLE_CYC       = (SETTLE_MAX_NS * 1000) / CLK_PERIOD_PS;

  // register write strobe carried from the serial front end
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [15:0] data;
  } reg_wr_t;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SLEW} steer_state_t;

endpackage : freq_steer_pkg

// ===== slew_ramp.sv
// linear ramp from the present offset toward a target over a fixed cycle count
`timescale 1ns/1ps
module slew_ramp
  import freq_steer_pkg::*;
#(
  parameter int STEPS = SETTLE_CYC
) (
  input  wire logic              core_clk,  // core clock
  input  wire logic              rst,       // async reset, active high
  input  wire logic              start,     // begin a ramp to target
  input  wire logic [WORD_W-1:0] target,    // signed target word
  output logic      [WORD_W-1:0] value_q,   // present applied word
  output logic                   busy_q     // ramp in progress
);
  localparam int CW = $clog2(STEPS + 1);
  logic signed [WORD_W+1:0] step_q;
  logic signed [WORD_W+1:0] delta;
  logic        [CW-1:0]     left_q;

  // per-step increment is the full distance spread over the window
  assign delta = $signed({{2{target[WORD_W-1]}}, target}) - $signed({{2{value_q[WORD_W-1]}}, value_q});

  // ramp counter and output; the last step lands exactly on target
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      value_q <= '0;
      step_q  <= '0;
      left_q  <= '0;
      busy_q  <= 1'b0;
    end else if (start) begin
      step_q  <= delta / $signed((WORD_W+2)'(STEPS));
      left_q  <= CW'(STEPS);
      busy_q  <= 1'b1;
    end else if (busy_q) begin
      left_q <= left_q - CW'(1);
      if (left_q == CW'(1)) begin
        value_q <= target;
        busy_q  <= 1'b0;
      end else begin
        value_q <= WORD_W'($signed({{2{value_q[WORD_W-1]}}, value_q}) + step_q);
      end
    end
  end
endmodule : slew_ramp

// ===== freq_steer_regs.sv
// frequency control word register bank with pull delay and settling ramp
`timescale 1ns/1ps
module freq_steer_regs
  import freq_steer_pkg::*;
#(
  parameter int PULL_DELAY = PULL_DELAY_CYC,  // cycles from upper write to pull start
  parameter int SETTLE     = SETTLE_CYC       // cycles of the settling ramp
) (
  input  wire logic              core_clk,       // core clock, 250 MHz
  input  wire logic              rst,            // async reset, active high
  input  reg_wr_t                reg_wr,         // register write strobe from serial front end
  input  wire logic [7:0]        rd_addr,        // register read address
  output logic      [15:0]       rd_data,        // register read data
  input  wire logic              soe_mode,       // strap: 1 = software enable, 0 = pin enable
  input  wire logic              oe_pin,         // output enable pin, asynchronous
  output logic                   out_enable_q,   // output driver enable
  output logic      [3:0]        pull_span_q,    // selected pull span code
  output logic      [WORD_W-1:0] applied_word,   // word currently steering the oscillator
  output logic                   pulling,        // frequency in motion
  output logic                   update_busy_q   // a written word not yet fully applied
);
  logic [15:0]       word_low_q;
  logic [9:0]        word_high_q;
  logic              soe_bit_q;
  logic [WORD_W-1:0] target_q;
  logic              oe_meta_q;
  logic              oe_sync_q;
  logic              soe_meta_q;
  logic              soe_mode_q;
  logic              hi_wr;
  logic              ramp_start;
  logic              ramp_busy;
  steer_state_t      state_q;
  logic [$clog2(PULL_DELAY+1)-1:0] dly_q;

  // ==========================================================
  // register writes; auto-increment is done in the serial front end
  assign hi_wr = reg_wr.valid && reg_wr.addr == ADDR_WORD_HIGH;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_low_q  <= WORD_LOW_RESET;
      word_high_q <= WORD_HIGH_RESET;
      soe_bit_q   <= SOE_RESET;
      pull_span_q <= PULL_SPAN_RESET;
    end else if (reg_wr.valid) begin
      unique case (reg_wr.addr)
        ADDR_WORD_LOW: word_low_q <= reg_wr.data;
        ADDR_WORD_HIGH: begin
          word_high_q <= reg_wr.data[HIGH_FIELD_MSB:0];
          soe_bit_q   <= reg_wr.data[SOE_BIT_POS];
        end
        ADDR_PULL_SPAN: pull_span_q <= reg_wr.data[SPAN_FIELD_MSB:0];
        default: ;
      endcase
    end
  end

  // target latched only at the upper write so a lone low write changes nothing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      target_q <= '0;
    end else if (hi_wr) begin
      target_q <= {reg_wr.data[HIGH_FIELD_MSB:0], word_low_q};
    end
  end

  // ==========================================================
  // pull start delay, then hand the target to the ramp
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      dly_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (hi_wr) begin
          state_q <= ST_DELAY;
          dly_q   <= '0;
        end
        ST_DELAY: begin
          // a new upper write restarts the wait so the latest word wins
          if (hi_wr) dly_q <= '0;
          else if (dly_q == $bits(dly_q)'(PULL_DELAY - 1)) state_q <= ST_SLEW;
          else dly_q <= dly_q + 1'b1;
        end
        ST_SLEW: if (hi_wr) begin
          state_q <= ST_DELAY;
          dly_q   <= '0;
        end else if (!ramp_busy) state_q <= ST_IDLE;
      endcase
    end
  end

  assign ramp_start = state_q == ST_DELAY && !hi_wr && dly_q == $bits(dly_q)'(PULL_DELAY - 1);

  slew_ramp #(
    .STEPS(SETTLE)
  ) u_ramp (
    .core_clk(core_clk),
    .rst     (rst),
    .start   (ramp_start),
    .target  (target_q),
    .value_q (applied_word),
    .busy_q  (ramp_busy)
  );

  assign pulling = ramp_busy;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) update_busy_q <= 1'b0;
    else update_busy_q <= hi_wr || (state_q != ST_IDLE && !(state_q == ST_SLEW && !ramp_busy));
  end

  // ==========================================================
  // output enable: pin synchronised and cleared by reset, strap synchronised through two flops with no reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oe_meta_q <= 1'b0;
      oe_sync_q <= 1'b0;
    end else begin
      oe_meta_q <= oe_pin;
      oe_sync_q <= oe_meta_q;
    end
  end

  // strap comes from a pin, so it passes two flops like the enable pin;
  // no reset here: the strap is valid two edges after the clock starts, whether or not reset is held
  always_ff @(posedge core_clk) begin
    soe_meta_q <= soe_mode;
    soe_mode_q <= soe_meta_q;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) out_enable_q <= 1'b0;
    else if (soe_mode_q) out_enable_q <= soe_bit_q;
    else out_enable_q <= oe_sync_q;
  end

  // ==========================================================
  // read mux; unused bits and addresses read zero
  always_comb begin
    rd_data = 16'h0000;
    unique case (rd_addr)
      ADDR_WORD_LOW:  rd_data = word_low_q;
      ADDR_WORD_HIGH: rd_data = {5'h00, soe_bit_q, word_high_q};
      ADDR_PULL_SPAN: rd_data = {12'h000, pull_span_q};
      default:        rd_data = 16'h0000;
    endcase
  end
endmodule : freq_steer_regs

// ===== freq_host_model.sv
// host model that writes the steering registers over the register port
`timescale 1ns/1ps
module freq_host_model
  import freq_steer_pkg::*;
#(
  parameter int GAP = 6579  // cycles between word updates, 38 kHz at 250 MHz
) (
  input  wire logic core_clk,  // core clock
  output reg_wr_t   reg_wr     // register write strobe
);
  // ==========
  // idle payload is inverted so a stale copy never passes for data
  initial reg_wr = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr <= {1'b1, a, d};
    @(posedge core_clk);
    reg_wr <= {1'b0, ~a, ~d};
    @(posedge core_clk);
  endtask : wr
  // lower half first, then upper bits with enable, back to back
  task automatic put_word(input logic [25:0] w, input logic oe);
    reg_wr <= {1'b1, ADDR_WORD_LOW, w[15:0]};
    @(posedge core_clk);
    wr(ADDR_WORD_HIGH, {5'h00, oe, w[25:16]});
    repeat (GAP) @(posedge core_clk);
  endtask : put_word
endmodule : freq_host_model

// ===== freq_steer_regs_chk.sv
// port checks for the steering register bank
`timescale 1ns/1ps
module freq_steer_regs_chk
  import freq_steer_pkg::*;
#(
  parameter int PULL_DELAY = PULL_DELAY_CYC,  // pull start delay
  parameter int SETTLE     = SETTLE_CYC       // ramp length
) (
  input wire logic              core_clk,      // clock
  input wire logic              rst,           // reset
  input reg_wr_t                reg_wr,        // write strobe
  input wire logic              soe_mode,      // enable strap
  input wire logic              oe_pin,        // enable pin
  input wire logic              out_enable_q,  // driver on
  input wire logic [3:0]        pull_span_q,   // span code
  input wire logic [WORD_W-1:0] applied_word,  // steering word
  input wire logic              pulling,       // in motion
  input wire logic              update_busy_q  // word pending
);
  logic        hi_w;
  logic [15:0] since_q;
  logic [15:0] low_q;
  logic [25:0] tgt_q;
  assign hi_w = reg_wr.valid && reg_wr.addr == ADDR_WORD_HIGH;
  // ==========
  // cycles since last upper write; parked at all ones so idle time never matches
  always_ff @(posedge core_clk or posedge rst)
    if (rst) since_q <= '1;
    else if (hi_w) since_q <= '0;
    else if (since_q != '1) since_q <= since_q + 16'h0001;
  // expected word, built as the halves arrive
  always_ff @(posedge core_clk or posedge rst)
    if (rst) low_q <= WORD_LOW_RESET;
    else if (reg_wr.valid && reg_wr.addr == ADDR_WORD_LOW) low_q <= reg_wr.data;
  always_ff @(posedge core_clk or posedge rst)
    if (rst) tgt_q <= '0;
    else if (hi_w) tgt_q <= {reg_wr.data[9:0], low_q};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_SPAN: assert property (reg_wr.valid && reg_wr.addr == ADDR_PULL_SPAN |=>
    pull_span_q == $past(reg_wr.data[3:0])) else $error("span code not stored");
  AST_SOE: assert property ((hi_w && soe_mode) ##1 (soe_mode && !hi_w) |=>
    out_enable_q == $past(reg_wr.data[10], 2)) else $error("software enable not followed");
  AST_PIN: assert property ((!soe_mode && $stable(oe_pin)) [*5] |-> out_enable_q == oe_pin)
    else $error("pin enable not followed");
  AST_BOOT: assert property ($fell(rst) ##0 (soe_mode && !hi_w) [*4] |-> !out_enable_q)
    else $error("driver on after reset");
  AST_BUSY: assert property (hi_w |=> update_busy_q) else $error("upper write not taken");
  AST_START: assert property ($rose(pulling) |-> since_q >= PULL_DELAY - 1 && since_q <= PULL_DELAY + 2)
    else $error("pull start off time");
  AST_LATE: assert property (since_q == PULL_DELAY + 3 |-> pulling) else $error("pull start late");
  AST_DONE: assert property ($fell(update_busy_q) |-> applied_word == tgt_q && since_q < PULL_DELAY + SETTLE + 4)
    else $error("word not reached in time");
  AST_LOW: assert property ((reg_wr.valid && reg_wr.addr == ADDR_WORD_LOW && !update_busy_q) ##1 !hi_w |=>
    !update_busy_q && $stable(applied_word)) else $error("lower half moved the word");
endmodule : freq_steer_regs_chk

// ===== freq_steer_regs_tb.sv
// self-checking bench for the steering register bank
`timescale 1ns/1ps
module freq_steer_regs_tb
  import freq_steer_pkg::*;
;
  logic              core_clk, rst, soe_mode, oe_pin, out_enable_q, pulling, update_busy_q;
  logic [7:0]        rd_addr;
  logic [15:0]       rd_data;
  logic [3:0]        pull_span_q;
  logic [WORD_W-1:0] applied_word;
  reg_wr_t           reg_wr;
  int                errors, samples_checked;
  // span code and rounded two's complement word per update
  typedef struct packed {logic [3:0] code; logic [25:0] word;} row_t;
  row_t rows [4] = '{'{4'h5, 26'h0e6_6666}, '{4'hc, 26'h380_0000}, '{4'h3, 26'h066_6666}, '{4'hf, 26'h1ff_ffff}};
  freq_host_model host (.core_clk(core_clk), .reg_wr(reg_wr));
  // short delay and ramp keep the run brief
  freq_steer_regs #(.PULL_DELAY(20), .SETTLE(8)) dut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
    .rd_addr(rd_addr), .rd_data(rd_data), .soe_mode(soe_mode), .oe_pin(oe_pin), .out_enable_q(out_enable_q),
    .pull_span_q(pull_span_q), .applied_word(applied_word), .pulling(pulling), .update_busy_q(update_busy_q));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_addr <= a;
    @(posedge core_clk);
    #1 check(rd_data, e);
    @(posedge core_clk);
  endtask : rd
  task automatic complete_run();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // ==========
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // watchdog: four spaced updates take about 105 us
  initial begin
    #300_000;
    errors++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    soe_mode = 1'b1;
    oe_pin = 1'b0;
    rd_addr = 8'h00;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check(out_enable_q, 1'b0);
    foreach (rows[i]) begin
      host.wr(ADDR_PULL_SPAN, {12'hfff, rows[i].code});
      rd(ADDR_PULL_SPAN, {12'h000, rows[i].code});
      check(pull_span_q, rows[i].code);
      host.put_word(rows[i].word, i[0]);
      check(applied_word, rows[i].word);
      check(pulling, 1'b0);
      check(update_busy_q, 1'b0);
      check(out_enable_q, i[0]);
      rd(ADDR_WORD_HIGH, {5'h00, i[0], rows[i].word[25:16]});
    end
    // lower half alone leaves the word in force
    host.wr(ADDR_WORD_LOW, 16'h1234);
    repeat (40) @(posedge core_clk);
    check(applied_word, rows[3].word);
    host.wr(8'h07, 16'hffff);
    rd(8'h07, 16'h0000);
    // pin mode: the software bit must not reach the driver
    soe_mode <= 1'b0;
    host.wr(ADDR_WORD_HIGH, 16'h0400);
    repeat (8) @(posedge core_clk);
    check(out_enable_q, 1'b0);
    oe_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    check(out_enable_q, 1'b1);
    // reset in mid-ramp, then the driver stays off in software mode
    soe_mode <= 1'b1;
    repeat (10) @(posedge core_clk);
    check(pulling, 1'b1);
    check(out_enable_q, 1'b1);
    rst <= 1'b1;
    @(posedge core_clk);
    #1 check(applied_word, 26'h000_0000);
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(out_enable_q, 1'b0);
    complete_run();
  end
endmodule : freq_steer_regs_tb
bind freq_steer_regs freq_steer_regs_chk #(.PULL_DELAY(PULL_DELAY), .SETTLE(SETTLE)) chk (.core_clk(core_clk),
  .rst(rst), .reg_wr(reg_wr), .soe_mode(soe_mode), .oe_pin(oe_pin), .out_enable_q(out_enable_q),
  .pull_span_q(pull_span_q), .applied_word(applied_word), .pulling(pulling), .update_busy_q(update_busy_q));
